//--- core/dbgcf_fifo_mem.v
`timescale 1ns/100ps
module dbgcf_fifo_mem #(
  parameter WIDTH = 16,
  parameter ADDR_W = 3
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  // Write port
  input wire wr_en_i,
  input wire [ADDR_W-1:0] wr_addr_i,
  input wire [WIDTH-1:0] wr_data_i,
  // Read port
  input wire [ADDR_W-1:0] rd_addr_i,
  output reg [WIDTH-1:0] rd_data_o
);

  reg [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

  // Storage has no reset; only the read register does
  always @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Registered read, one cycle behind the address
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_o <= {WIDTH{1'b0}};
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

//--- core/dbgcf_map.vh
`ifndef DBGCF_MAP_VH
`define DBGCF_MAP_VH

// Register indices; byte address is four times the index
`define DBGCF_IDX_CMP_B_LOW 14'h3013
`define DBGCF_IDX_CMP_C_HIGH 14'h3014
`define DBGCF_IDX_CMP_C_LOW 14'h3015
`define DBGCF_IDX_FIFO_HIGH 14'h3016
`define DBGCF_IDX_FIFO_LOW 14'h3017
`define DBGCF_IDX_CMP_A_DIR 14'h3018

// Reset values
`define DBGCF_RST_CMP_B_LOW 8'h00
`define DBGCF_RST_CMP_C_HIGH 8'h00
`define DBGCF_RST_CMP_C_LOW 8'h00
`define DBGCF_RST_CMP_A_DIR 8'h00
`define DBGCF_RST_READ_DATA 8'h00

// Field positions of the comparator A direction extension
`define DBGCF_DIR_ENABLE_BIT 7
`define DBGCF_DIR_VALUE_BIT 6
`define DBGCF_DIR_WRITABLE 8'hc0

// Bus answers
`define DBGCF_RESP_OKAY 2'b00
`define DBGCF_RESP_SLVERR 2'b10

// Trace FIFO shape
`define DBGCF_FIFO_WIDTH 16
`define DBGCF_FIFO_DEPTH_LOG2 3

`endif

//--- core/dbgcf_regs.v
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "dbgcf_map.vh"
// Notes on behaviour
// - Each bit of the comparator B low byte picks whether address bit 7..0 must be 1 or 0.
// - Each bit of the comparator C high byte picks whether address bit 15..8 must be 1 or 0.
// - Each bit of the comparator C low byte picks whether address bit 7..0 must be 1 or 0.
// - Power-on reset or a non-end-run reset, unless debug enable is 1 and begin select 0, clears every bit of these registers.
// - After an end-run reset the register contents are undefined and not checked.
// - A reset ending a trace with debug enable 1 and begin select 0 keeps the contents.
// - The FIFO high readout shows bits 15..8 of the word at the read position.
// - In event-only modes the FIFO high readout returns zero for every valid word.
// - The FIFO low readout shows bits 7..0 of the word and a read advances the pointer.
// - Bit 7 of the comparator A extension makes read/write direction part of the match.
// - Bit 6 of the comparator A extension picks write (0) or read (1) when enabled.
// - The reserved bits of the comparator A extension are read-only and read zero.
module dbgcf_regs #(
  parameter ADDR_W = 16,
  parameter FIFO_WIDTH = `DBGCF_FIFO_WIDTH,
  parameter FIFO_DEPTH_LOG2 = `DBGCF_FIFO_DEPTH_LOG2
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  // Reset kinds from the system
  input wire sys_reset_i,
  input wire end_run_reset_i,
  input wire debug_unit_enable_i,
  input wire begin_trigger_sel_i,
  // Monitored CPU bus
  input wire cpu_valid_i,
  input wire [15:0] cpu_addr_i,
  input wire cpu_rw_i,
  // Trace capture
  input wire trace_push_i,
  input wire [FIFO_WIDTH-1:0] trace_data_i,
  input wire event_only_mode_i,
  // Comparator results and FIFO empty flag
  output reg cmp_b_low_match_o,
  output reg cmp_c_match_o,
  output reg cmp_a_dir_ok_o,
  output reg fifo_empty_o,
  // AXI4-Lite write address
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp
);

  localparam PTR_W = FIFO_DEPTH_LOG2 + 1;

  // Software-visible state
  reg [7:0] comparator_b_low_byte;
  reg [7:0] comparator_c_high_byte;
  reg [7:0] comparator_c_low_byte;
  reg [7:0] comparator_a_direction_ext;

  // FIFO pointers carry one wrap bit for honest full and empty
  reg [PTR_W-1:0] wr_ptr;
  reg [PTR_W-1:0] rd_ptr;
  wire [FIFO_WIDTH-1:0] fifo_word;

  // Write channel holding registers
  reg aw_held;
  reg w_held;
  reg [ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // Reset that clears versus reset that preserves
  wire keep_on_reset = debug_unit_enable_i & ~begin_trigger_sel_i;
  // End-run contents are undefined, so keeping them is a legal choice
  wire clear_now = sys_reset_i & ~keep_on_reset & ~end_run_reset_i;

  wire fifo_empty = (wr_ptr == rd_ptr);
  wire fifo_full = (wr_ptr[PTR_W-1] != rd_ptr[PTR_W-1]) &&
                   (wr_ptr[PTR_W-2:0] == rd_ptr[PTR_W-2:0]);

  // Index decode of both channels; low two address bits ignored
  wire [ADDR_W-3:0] wr_idx = aw_addr[ADDR_W-1:2];
  wire [ADDR_W-3:0] rd_idx = s_axi_araddr[ADDR_W-1:2];

  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire do_read = s_axi_arvalid & s_axi_arready;

  // Read of the low byte pops the FIFO when a word is present
  wire pop = do_read && (rd_idx == `DBGCF_IDX_FIFO_LOW) && !fifo_empty;
  wire push = trace_push_i && !fifo_full; // Words arriving while full are dropped

  reg wr_mapped;
  reg rd_mapped;
  reg [7:0] rd_byte;

  // Write address map
  always @* begin
    case (wr_idx)
      `DBGCF_IDX_CMP_B_LOW: wr_mapped = 1'b1;
      `DBGCF_IDX_CMP_C_HIGH: wr_mapped = 1'b1;
      `DBGCF_IDX_CMP_C_LOW: wr_mapped = 1'b1;
      `DBGCF_IDX_FIFO_HIGH: wr_mapped = 1'b1;
      `DBGCF_IDX_FIFO_LOW: wr_mapped = 1'b1;
      `DBGCF_IDX_CMP_A_DIR: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  // Read multiplexer; an empty FIFO reads zero
  always @* begin
    rd_mapped = 1'b1;
    rd_byte = 8'h00;
    case (rd_idx)
      `DBGCF_IDX_CMP_B_LOW: rd_byte = comparator_b_low_byte;
      `DBGCF_IDX_CMP_C_HIGH: rd_byte = comparator_c_high_byte;
      `DBGCF_IDX_CMP_C_LOW: rd_byte = comparator_c_low_byte;
      `DBGCF_IDX_FIFO_HIGH: begin
        if (!fifo_empty && !event_only_mode_i) begin
          rd_byte = fifo_word[15:8];
        end
      end
      `DBGCF_IDX_FIFO_LOW: begin
        if (!fifo_empty) begin
          rd_byte = fifo_word[7:0];
        end
      end
      `DBGCF_IDX_CMP_A_DIR: rd_byte = comparator_a_direction_ext & `DBGCF_DIR_WRITABLE;
      default: rd_mapped = 1'b0;
    endcase
  end

  // Write address and data are caught independently, in either order
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      // Reopen both channels only once the response is taken
      if (s_axi_bvalid && s_axi_bready) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response one cycle after both halves are held
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DBGCF_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? `DBGCF_RESP_OKAY : `DBGCF_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Registers written through byte lane 0; FIFO readouts ignore writes
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      comparator_b_low_byte <= `DBGCF_RST_CMP_B_LOW;
      comparator_c_high_byte <= `DBGCF_RST_CMP_C_HIGH;
      comparator_c_low_byte <= `DBGCF_RST_CMP_C_LOW;
      comparator_a_direction_ext <= `DBGCF_RST_CMP_A_DIR;
    end else if (clear_now) begin
      comparator_b_low_byte <= `DBGCF_RST_CMP_B_LOW;
      comparator_c_high_byte <= `DBGCF_RST_CMP_C_HIGH;
      comparator_c_low_byte <= `DBGCF_RST_CMP_C_LOW;
      comparator_a_direction_ext <= `DBGCF_RST_CMP_A_DIR;
    end else if (do_write && w_strb[0] && !sys_reset_i) begin
      case (wr_idx)
        `DBGCF_IDX_CMP_B_LOW: comparator_b_low_byte <= w_data[7:0];
        `DBGCF_IDX_CMP_C_HIGH: comparator_c_high_byte <= w_data[7:0];
        `DBGCF_IDX_CMP_C_LOW: comparator_c_low_byte <= w_data[7:0];
        `DBGCF_IDX_CMP_A_DIR: begin
          comparator_a_direction_ext <= w_data[7:0] & `DBGCF_DIR_WRITABLE;
        end
        default: comparator_a_direction_ext <= comparator_a_direction_ext;
      endcase
    end
  end

  // Read channel: one request at a time, data one cycle after acceptance
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DBGCF_RESP_OKAY;
    end else if (do_read) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_mapped ? `DBGCF_RESP_OKAY : `DBGCF_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // FIFO pointers; a cleared reset also empties the FIFO
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr <= {PTR_W{1'b0}};
      rd_ptr <= {PTR_W{1'b0}};
      fifo_empty_o <= 1'b1;
    end else if (clear_now) begin
      wr_ptr <= {PTR_W{1'b0}};
      rd_ptr <= {PTR_W{1'b0}};
      fifo_empty_o <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
      end
      fifo_empty_o <= ((push ? wr_ptr + {{(PTR_W-1){1'b0}}, 1'b1} : wr_ptr) ==
                       (pop ? rd_ptr + {{(PTR_W-1){1'b0}}, 1'b1} : rd_ptr));
    end
  end

  // Address and direction compare, registered for a clean output
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmp_b_low_match_o <= 1'b0;
      cmp_c_match_o <= 1'b0;
      cmp_a_dir_ok_o <= 1'b0;
    end else begin
      cmp_b_low_match_o <= cpu_valid_i && (cpu_addr_i[7:0] == comparator_b_low_byte);
      cmp_c_match_o <= cpu_valid_i &&
                       (cpu_addr_i[15:8] == comparator_c_high_byte) &&
                       (cpu_addr_i[7:0] == comparator_c_low_byte);
      // Direction only counts while its enable is set
      cmp_a_dir_ok_o <= cpu_valid_i &&
                        (!comparator_a_direction_ext[`DBGCF_DIR_ENABLE_BIT] ||
                         (cpu_rw_i == comparator_a_direction_ext[`DBGCF_DIR_VALUE_BIT]));
    end
  end

  // Read address tracks the pointer; the word lags a pop by one cycle,
  // which the one-request-at-a-time read channel always covers
  dbgcf_fifo_mem #(
    .WIDTH(FIFO_WIDTH),
    .ADDR_W(FIFO_DEPTH_LOG2)
  ) u_fifo_mem (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .wr_en_i(push),
    .wr_addr_i(wr_ptr[PTR_W-2:0]),
    .wr_data_i(trace_data_i),
    .rd_addr_i(rd_ptr[PTR_W-2:0]),
    .rd_data_o(fifo_word)
  );

endmodule

//--- dv/dbgcf_cpu_model.sv
`timescale 1ns/100ps
module dbgcf_cpu_model (
  // Clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  // Request from the bench
  input wire req_i,
  input wire [15:0] addr_i,
  input wire rw_i,
  // Bus cycle towards the comparators
  output reg cpu_valid_o,
  output reg [15:0] cpu_addr_o,
  output reg cpu_rw_o
);
  // One cycle per request; idle lines toggle so stale values never match by luck
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpu_valid_o <= 1'b0;
      cpu_addr_o <= 16'hffff;
      cpu_rw_o <= 1'b0;
    end else if (req_i) begin
      cpu_valid_o <= 1'b1;
      cpu_addr_o <= addr_i;
      cpu_rw_o <= rw_i;
    end else begin
      cpu_valid_o <= 1'b0;
      cpu_addr_o <= ~cpu_addr_o;
      cpu_rw_o <= ~cpu_rw_o;
    end
  end
endmodule

//--- dv/dbgcf_regs_props.sv
`timescale 1ns/100ps
module dbgcf_regs_props (
  // Clock, resets, CPU bus valid and trace
  input wire ref_clk_i,
  input wire resetn_i,
  input wire sys_reset_i,
  input wire cpu_valid_i,
  input wire trace_push_i,
  // Comparator results and FIFO empty flag
  input wire cmp_b_low_match_o,
  input wire cmp_c_match_o,
  input wire cmp_a_dir_ok_o,
  input wire fifo_empty_o,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // Both halves of a write taken in the same cycle
  sequence s_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ar;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_aw_drop; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  a_aw_drop: assert property (p_aw_drop) else $error("awready high after address taken");
  property p_b_after; s_both |-> ##[1:2] s_axi_bvalid; endproperty
  a_b_after: assert property (p_b_after) else $error("write response missing");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped before bready");
  property p_r_after; s_ar |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_r_after: assert property (p_r_after) else $error("read data not one cycle after address");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data moved before rready");
  property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_r_upper: assert property (p_r_upper) else $error("upper read lanes not zero");
  // Registered compare results need a bus cycle behind them
  property p_cmp_idle;
    !cpu_valid_i |=> !cmp_b_low_match_o && !cmp_c_match_o && !cmp_a_dir_ok_o;
  endproperty
  a_cmp_idle: assert property (p_cmp_idle) else $error("match without bus cycle");
  property p_fifo_fill; trace_push_i && fifo_empty_o && !sys_reset_i |-> ##[1:2] !fifo_empty_o;
  endproperty
  a_fifo_fill: assert property (p_fifo_fill) else $error("pushed word not visible");
endmodule
bind dbgcf_regs dbgcf_regs_props u_props (.ref_clk_i, .resetn_i, .sys_reset_i, .cpu_valid_i,
  .trace_push_i, .cmp_b_low_match_o, .cmp_c_match_o, .cmp_a_dir_ok_o, .fifo_empty_o,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

//--- dv/debug_comparator_fifo_regs_test.sv
`timescale 1ns/100ps
`include "dbgcf_map.vh"
module debug_comparator_fifo_regs_test;
  reg ref_clk_i = 1'b0;
  reg resetn_i = 1'b0;
  reg sys_rst = 1'b0, end_run = 1'b0, dbg_en = 1'b0, beg_sel = 1'b0, ev_only = 1'b0;
  reg req = 1'b0, rw = 1'b0, push = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  reg [15:0] addr = 16'h0, tdata = 16'h0, awaddr = 16'h0, araddr = 16'h0;
  reg [31:0] wdata = 32'h0, got;
  reg [1:0] resp;
  reg [13:0] k;
  wire cv, crw, m_b, m_c, m_a, empty, awready, wready, bvalid, arready, rvalid;
  wire [15:0] caddr;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer n_mismatch = 0, n_compared = 0, cyc = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  dbgcf_cpu_model u_cpu (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .req_i(req),
    .addr_i(addr), .rw_i(rw), .cpu_valid_o(cv), .cpu_addr_o(caddr), .cpu_rw_o(crw));
  // Prot, strobes and response readies held constant: the master always accepts
  dbgcf_regs uut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sys_reset_i(sys_rst),
    .end_run_reset_i(end_run), .debug_unit_enable_i(dbg_en), .begin_trigger_sel_i(beg_sel),
    .cpu_valid_i(cv), .cpu_addr_i(caddr), .cpu_rw_i(crw), .trace_push_i(push),
    .trace_data_i(tdata), .event_only_mode_i(ev_only), .cmp_b_low_match_o(m_b),
    .cmp_c_match_o(m_c), .cmp_a_dir_ok_o(m_a), .fifo_empty_o(empty),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp));
  task wrap_up;
    begin
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  // Hang guard, well above the roughly 115 cycles the sequence needs
  always @(posedge ref_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up;
    end
  end
  task chk(input [31:0] seen, input [31:0] want);
    begin
      n_compared = n_compared + 1;
      if (seen !== want) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, want);
      end
    end
  endtask
  // Address and data offered together, each released once taken
  task wr(input [13:0] idx, input [7:0] d, input [1:0] er);
    reg a, w;
    begin
      a = 1'b0;
      w = 1'b0;
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(a && w)) begin
        @(posedge ref_clk_i);
        if (awvalid && awready) begin
          a = 1'b1;
          awvalid <= 1'b0;
        end
        if (wvalid && wready) begin
          w = 1'b1;
          wvalid <= 1'b0;
        end
      end
      do @(posedge ref_clk_i); while (!bvalid);
      chk(bresp, er);
    end
  endtask
  task rd(input [13:0] idx, input [31:0] want, input [1:0] er);
    begin
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      do @(posedge ref_clk_i); while (!arready);
      arvalid <= 1'b0;
      do @(posedge ref_clk_i); while (!rvalid);
      chk(rdata, want);
      chk(rresp, er);
    end
  endtask
  // Result is sampled two edges after the cycle reaches the comparators
  task cpu(input [15:0] a, input r, input [2:0] e);
    begin
      req <= 1'b1;
      addr <= a;
      rw <= r;
      @(posedge ref_clk_i);
      req <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      chk({m_b, m_c, m_a}, e);
    end
  endtask
  task push_w(input [15:0] w);
    begin
      tdata <= w;
      push <= 1'b1;
      @(posedge ref_clk_i);
      push <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
    end
  endtask
  task sreset(input en, input bs, input er);
    begin
      dbg_en <= en;
      beg_sel <= bs;
      end_run <= er;
      sys_rst <= 1'b1;
      @(posedge ref_clk_i);
      sys_rst <= 1'b0;
      @(posedge ref_clk_i);
    end
  endtask
  initial begin
    repeat (20) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    for (k = 14'h3013; k < 14'h3019; k = k + 14'h1) rd(k, 32'h0, `DBGCF_RESP_OKAY);
    wr(`DBGCF_IDX_CMP_B_LOW, 8'h5a, `DBGCF_RESP_OKAY);
    wr(`DBGCF_IDX_CMP_C_HIGH, 8'ha5, `DBGCF_RESP_OKAY);
    wr(`DBGCF_IDX_CMP_C_LOW, 8'h3c, `DBGCF_RESP_OKAY);
    wr(`DBGCF_IDX_CMP_A_DIR, 8'hff, `DBGCF_RESP_OKAY);
    wr(14'h3020, 8'h11, `DBGCF_RESP_SLVERR);
    rd(14'h3020, 32'h0, `DBGCF_RESP_SLVERR);
    rd(`DBGCF_IDX_CMP_A_DIR, 32'hc0, `DBGCF_RESP_OKAY);
    rd(`DBGCF_IDX_CMP_C_HIGH, 32'ha5, `DBGCF_RESP_OKAY);
    cpu(16'ha53c, 1'b1, 3'b011);
    cpu(16'ha53c, 1'b0, 3'b010);
    cpu(16'h125a, 1'b1, 3'b101);
    cpu(16'ha43c, 1'b1, 3'b001);
    wr(`DBGCF_IDX_CMP_A_DIR, 8'h40, `DBGCF_RESP_OKAY);
    cpu(16'ha53d, 1'b0, 3'b001);
    push_w(16'h1234);
    push_w(16'habcd);
    rd(`DBGCF_IDX_FIFO_HIGH, 32'h12, `DBGCF_RESP_OKAY);
    rd(`DBGCF_IDX_FIFO_LOW, 32'h34, `DBGCF_RESP_OKAY);
    rd(`DBGCF_IDX_FIFO_HIGH, 32'hab, `DBGCF_RESP_OKAY);
    rd(`DBGCF_IDX_FIFO_LOW, 32'hcd, `DBGCF_RESP_OKAY);
    chk(empty, 32'h1);
    ev_only <= 1'b1;
    push_w(16'h55aa);
    push_w(16'h66bb);
    rd(`DBGCF_IDX_FIFO_HIGH, 32'h0, `DBGCF_RESP_OKAY);
    rd(`DBGCF_IDX_FIFO_LOW, 32'haa, `DBGCF_RESP_OKAY);
    rd(`DBGCF_IDX_FIFO_LOW, 32'hbb, `DBGCF_RESP_OKAY);
    ev_only <= 1'b0;
    push_w(16'h7788);
    sreset(1'b1, 1'b0, 1'b0);
    rd(`DBGCF_IDX_CMP_C_LOW, 32'h3c, `DBGCF_RESP_OKAY);
    rd(`DBGCF_IDX_FIFO_HIGH, 32'h77, `DBGCF_RESP_OKAY);
    // Contents after this one are undefined, so nothing is read back
    sreset(1'b0, 1'b1, 1'b1);
    sreset(1'b0, 1'b1, 1'b0);
    rd(`DBGCF_IDX_CMP_C_LOW, 32'h0, `DBGCF_RESP_OKAY);
    rd(`DBGCF_IDX_CMP_A_DIR, 32'h0, `DBGCF_RESP_OKAY);
    chk(empty, 32'h1);
    wrap_up;
  end
endmodule
